// file: core/opd_core.sv
// opd_core: per-output duty shaping and phase step / align sequencer, avalon-mm slave
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: duty shaping only when frequency, dividers allow
// R2: zero width gives 50%, else pulse periods
// R3: invert swaps pulse level and rest level
// R4: shaping in low divider; n-pin option
// R5: software avoids high/low times under 2ns
// R6: phase steps in medium divider, half periods
// R7: adjust mode needs enable, amount, arm, trigger
// R8: arm source chosen by prime_source_select
// R9: trigger source chosen by fire_source_select
// R10: fire_invert inverts the trigger signal
// R11: one trigger steps all enabled nonzero outputs
// R12: no step at zero; negative step limit
// R13: positive step limit from divider value
// R14: step changes one period's high time
// R15: sequencer_clear cancels armed step, back idle
// R16: live waiting/busy status, latched done flag
// R17: step amount counts half fast periods
// R18: fire_request self-clears only for slow dividers; here it clears on every completion, whatever the divider
// R19: software clears sequencer after source changes
// R20: align mode resets dividers before the step
// R21: opposite formats invert phase; invert restores
// R22: aligned groups share dividers; software's duty
// R23: trigger while not armed is ignored
module opd_core
    import opd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic apll_lock,
    input wire logic dpll_lock,
    input wire logic dpll_ref_clk,
    input wire logic [3:0] gpio,
    output logic [NUM_OUT-1:0] out_pos_pin,
    output logic [NUM_OUT-1:0] out_neg_pin
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic wait_q;                        // waitrequest flop, high while idle
    logic [31:0] rdata_q;                // read data, loaded as the answer forms
    logic wr_go;                         // write takes effect
    logic mode_q;                        // 1 adjust, 0 align
    logic prime_req_q;                   // prime_request bit
    logic fire_req_q;                    // fire_request bit
    logic fire_inv_q;                    // fire_invert bit
    logic clear_go;                      // sequencer_clear write
    logic [3:0] prime_sel_q;             // prime_source_select
    logic [3:0] fire_sel_q;              // fire_source_select
    logic done_q;                        // step_done_latched
    opd_seq_type seq_q;                  // sequencer state
    logic [6:0] sync1_q;                 // first stage, pins
    logic [6:0] sync2_q;                 // second stage, pins
    logic prime_lvl;                     // selected arm level
    logic fire_lvl;                      // selected trigger level
    logic prime_prev_q;                  // previous arm level
    logic fire_prev_q;                   // previous trigger level
    logic prime_evt;                     // arm event
    logic fire_evt;                      // trigger event
    logic fire_take;                     // trigger accepted while armed
    logic done_evt;                      // adjustment finished
    opd_chan_cfg_type cfg_q [NUM_OUT];   // channel control
    logic [LOW_DIV_W-1:0] ls_val_q [NUM_OUT]; // low_divider_value
    logic [7:0] duty_q [NUM_OUT];        // duty_pulse_width
    logic [7:0] step_q [NUM_OUT];        // phase_step_amount, signed
    logic [NUM_OUT-1:0] pend_q;          // step waiting for its period
    logic [NUM_OUT-1:0] align_q;         // divider reset pulse
    logic [NUM_OUT-1:0] ms_q;            // medium divider output
    logic [NUM_OUT-1:0] rise_q;          // medium output rose last edge
    logic [NUM_OUT-1:0] apply;           // step lands on this edge
    logic [NUM_OUT-1:0] pos_q;           // registered positive pin
    logic [NUM_OUT-1:0] neg_q;           // registered negative pin
    logic [1:0] sel_ch;                  // channel index of access
    logic ch_hit;                        // access falls in a channel window

    assign waitrequest = wait_q;
    assign readdata = rdata_q;
    assign out_pos_pin = pos_q;
    assign out_neg_pin = neg_q;

    // ----------------------------------------------------------------
    // avalon-mm slave
    // ----------------------------------------------------------------
    // channel windows sit at 0x10, 0x20, 0x30
    assign sel_ch = address[5:4] - 2'h1;
    assign ch_hit = (address[5:4] != 2'h0);
    // a request answers one edge after it is seen: wait_q drops for one cycle
    assign wr_go = write & ~wait_q;
    assign clear_go = wr_go && (address == OFS_PHASE_CONTROL_ONE) && writedata[PC_CLEAR_BIT];

    // waitrequest: low for exactly the completing cycle, then high again
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else if (ce) begin
            wait_q <= ~((read | write) & wait_q);
        end
    end

    // read data captured while waitrequest is still high, so it stands on the answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (ce && read && wait_q) begin
            rdata_q <= 32'h0000_0000;
            if (ch_hit) begin
                case (address[3:2])
                    CH_SUB_CTRL: rdata_q[11:0] <= cfg_q[sel_ch];
                    CH_SUB_LOW_DIV: rdata_q[LOW_DIV_W-1:0] <= ls_val_q[sel_ch];
                    CH_SUB_DUTY: rdata_q[7:0] <= duty_q[sel_ch];
                    default: rdata_q[7:0] <= step_q[sel_ch];
                endcase
            end else begin
                case (address)
                    OFS_PHASE_CONTROL_ONE: rdata_q[3:0] <= {fire_inv_q, fire_req_q,
                                                           prime_req_q, mode_q};
                    OFS_PHASE_SOURCE_CONFIG: rdata_q[7:0] <= {fire_sel_q, prime_sel_q};
                    // R16: live status and latched done
                    OFS_PHASE_STATUS_REG: rdata_q[2:0] <= {done_q, seq_q == SEQ_BUSY,
                                                          seq_q == SEQ_ARMED};
                    // unmapped words read as zero
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // global control registers
    // ----------------------------------------------------------------
    // software write wins over the self-clear of fire_request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q <= RST_MODE;
            prime_req_q <= 1'b0;
            fire_req_q <= 1'b0;
            fire_inv_q <= 1'b0;
        end else if (ce) begin
            if (wr_go && address == OFS_PHASE_CONTROL_ONE) begin
                mode_q <= writedata[PC_MODE_BIT];
                prime_req_q <= writedata[PC_PRIME_BIT];
                fire_req_q <= writedata[PC_FIRE_BIT];
                fire_inv_q <= writedata[PC_INV_BIT];
            end else if (done_evt) begin
                // R18: medium period never beats the master clock here, so self-clear
                fire_req_q <= 1'b0;
            end
        end
    end

    // source selectors; software must pulse sequencer_clear after a change
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prime_sel_q <= RST_PRIME_SEL;
            fire_sel_q <= RST_FIRE_SEL;
        end else if (ce && wr_go && address == OFS_PHASE_SOURCE_CONFIG) begin
            prime_sel_q <= writedata[PS_PRIME_LSB +: 4];
            fire_sel_q <= writedata[PS_FIRE_LSB +: 4];
        end
    end

    // R16: done flag; a completion in the clearing cycle still sets it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else if (ce) begin
            if (done_evt) begin
                done_q <= 1'b1;
            end else if (wr_go && address == OFS_PHASE_STATUS_REG && writedata[ST_DONE_BIT]) begin
                done_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // event sources
    // ----------------------------------------------------------------
    // pins are asynchronous: two flops before anything looks at them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_q <= 7'h00;
            sync2_q <= 7'h00;
        end else if (ce) begin
            sync1_q <= {gpio, dpll_ref_clk, dpll_lock, apll_lock};
            sync2_q <= sync1_q;
        end
    end

    // R8: arm source select
    always_comb begin
        case (prime_sel_q)
            SRC_PRIME_REQ: prime_lvl = prime_req_q;
            SRC_PRIME_APLL: prime_lvl = sync2_q[0];
            SRC_PRIME_DPLL: prime_lvl = sync2_q[1];
            4'h4, 4'h5, 4'h6, 4'h7: prime_lvl = sync2_q[3 + prime_sel_q[1:0]];
            default: prime_lvl = 1'b0;
        endcase
    end

    // R9: trigger source select; R10: optional inversion before edge detect
    always_comb begin
        case (fire_sel_q)
            SRC_FIRE_REQ: fire_lvl = fire_req_q;
            SRC_FIRE_APLL: fire_lvl = sync2_q[0];
            SRC_FIRE_DPLL: fire_lvl = sync2_q[1];
            SRC_FIRE_DREF: fire_lvl = sync2_q[2];
            4'h4, 4'h5, 4'h6, 4'h7: fire_lvl = sync2_q[3 + fire_sel_q[1:0]];
            default: fire_lvl = 1'b0;
        endcase
        fire_lvl = fire_lvl ^ fire_inv_q;
    end

    // edge memories; changing a selector can fake an edge, hence the clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prime_prev_q <= 1'b0;
            fire_prev_q <= 1'b0;
        end else if (ce) begin
            prime_prev_q <= prime_lvl;
            fire_prev_q <= fire_lvl;
        end
    end

    // rising edges of the selected levels
    assign prime_evt = prime_lvl & ~prime_prev_q;
    assign fire_evt = fire_lvl & ~fire_prev_q;
    // R23: trigger only counts while armed
    assign fire_take = fire_evt && (seq_q == SEQ_ARMED) && !clear_go;
    assign done_evt = (seq_q == SEQ_BUSY) && (pend_q == '0) && !clear_go;

    // ----------------------------------------------------------------
    // arm / trigger sequencer
    // ----------------------------------------------------------------
    // R7: step only after arm then trigger
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seq_q <= SEQ_IDLE;
        end else if (ce) begin
            if (clear_go) begin
                // R15: cancel and return idle
                seq_q <= SEQ_IDLE;
            end else begin
                case (seq_q)
                    SEQ_IDLE: if (prime_evt) begin
                        seq_q <= SEQ_ARMED;
                    end
                    SEQ_ARMED: if (fire_take) begin
                        seq_q <= SEQ_BUSY;
                    end
                    // busy ends when every stepped channel has landed
                    SEQ_BUSY: if (done_evt) begin
                        seq_q <= SEQ_IDLE;
                    end
                    default: seq_q <= SEQ_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // per-output channels
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_ch
        logic [6:0] msv;          // medium divider value
        logic [8:0] seg_q;        // clocks in current medium half
        logic [8:0] cnt_q;        // clocks spent in current half
        logic [7:0] neg_lim;      // largest negative step, half periods
        logic [7:0] pos_lim;      // largest positive step, half periods
        logic signed [9:0] amt;   // clamped step, half periods
        logic [8:0] hi_len;       // length of the stepped high half
        logic [LOW_DIV_W-1:0] ls_cnt_q; // medium periods into low cycle
        logic duty_ok;            // shaping allowed
        logic ls_lvl;             // low divider output level
        logic inv;                // effective output inversion
        logic [LOW_DIV_W-1:0] half_ls; // 50% high span

        assign msv = cfg_q[i].medium_divider_value;
        // R12: negative limit, (m-1)/2 odd or (m-2)/2 even, in fast periods
        assign neg_lim = {1'b0, 7'((msv - 7'h01) >> 1)} << 1;
        // R13: positive limit, (127-m)/2 odd or (128-m)/2 even
        assign pos_lim = {1'b0, 7'((8'h80 - {1'b0, msv}) >> 1)} << 1;

        // R17: amount is signed half periods; R6: one clock is one half period
        always_comb begin
            amt = 10'(signed'(step_q[i]));
            if (amt > signed'({2'b00, pos_lim})) begin
                amt = signed'({2'b00, pos_lim});
            end else if (amt < -signed'({2'b00, neg_lim})) begin
                amt = -signed'({2'b00, neg_lim});
            end
        end
        // R14: only this high half is stretched or shortened
        assign hi_len = 9'(10'(signed'({3'b000, msv})) + amt);

        // registers of this channel
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                cfg_q[i] <= RST_CHAN_CFG;
                ls_val_q[i] <= '0;
                duty_q[i] <= 8'h00;
                step_q[i] <= 8'h00;
            end else if (ce && wr_go && ch_hit && sel_ch == 2'(i)) begin
                case (address[3:2])
                    CH_SUB_CTRL: cfg_q[i] <= writedata[11:0];
                    CH_SUB_LOW_DIV: ls_val_q[i] <= writedata[LOW_DIV_W-1:0];
                    CH_SUB_DUTY: duty_q[i] <= writedata[7:0];
                    default: step_q[i] <= writedata[7:0];
                endcase
            end
        end

        // R11: every enabled channel with a nonzero amount and medium divider gets its own step
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                pend_q[i] <= 1'b0;
                align_q[i] <= 1'b0;
            end else if (ce) begin
                // R20: align mode resets participating dividers first
                align_q[i] <= fire_take && (mode_q == MODE_ALIGN) && cfg_q[i].phase_step_enable;
                if (clear_go) begin
                    pend_q[i] <= 1'b0;
                end else if (fire_take) begin
                    // R12: no step without a medium divider
                    pend_q[i] <= cfg_q[i].phase_step_enable && (step_q[i] != 8'h00)
                                 && (msv != 7'h00);
                end else if (apply[i]) begin
                    pend_q[i] <= 1'b0;
                end
            end
        end

        // step lands as the medium output turns high, never mid-reset
        assign apply[i] = pend_q[i] && !align_q[i] && (msv != 7'h00) && !ms_q[i]
                          && (cnt_q >= seg_q);

        // medium divider: high m clocks, low m clocks; zero bypasses it
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                ms_q[i] <= 1'b0;
                rise_q[i] <= 1'b0;
                cnt_q <= 9'h001;
                seg_q <= 9'h001;
            end else if (ce) begin
                rise_q[i] <= 1'b0;
                if (align_q[i]) begin
                    ms_q[i] <= 1'b0;
                    cnt_q <= 9'h001;
                    seg_q <= {2'b00, msv};
                end else if (msv == 7'h00) begin
                    ms_q[i] <= ~ms_q[i];
                    rise_q[i] <= ~ms_q[i];
                end else if (cnt_q >= seg_q) begin
                    ms_q[i] <= ~ms_q[i];
                    rise_q[i] <= ~ms_q[i];
                    cnt_q <= 9'h001;
                    seg_q <= apply[i] ? hi_len : {2'b00, msv};
                end else begin
                    cnt_q <= cnt_q + 9'h001;
                end
            end
        end

        // low divider counts medium periods, ratio value+1
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                ls_cnt_q <= '0;
            end else if (ce) begin
                if (align_q[i]) begin
                    ls_cnt_q <= '0;
                end else if (rise_q[i]) begin
                    ls_cnt_q <= (ls_cnt_q >= ls_val_q[i]) ? '0 : ls_cnt_q + 1'b1;
                end
            end
        end

        // R1: medium above zero, low above one, rate under the ceiling
        assign duty_ok = (msv != 7'h00) && (ls_val_q[i] > 25'd1)
            && (64'(FAST_KHZ) <= 64'(MAX_DUTY_KHZ) * 64'(msv) * (64'(ls_val_q[i]) + 64'd1));
        assign half_ls = 25'((26'(ls_val_q[i]) + 26'd1) >> 1);
        // R2: zero width is 50%, else high for width medium periods
        assign ls_lvl = (duty_ok && duty_q[i] != 8'h00)
                        ? (ls_cnt_q < 25'(duty_q[i])) : (ls_cnt_q < half_ls);
        // R3: invert swaps pulse and rest; R21: opposite formats start inverted
        assign inv = cfg_q[i].output_invert ^ cfg_q[i].format_opposite;

        // pins come from flops
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                pos_q[i] <= 1'b0;
                neg_q[i] <= 1'b0;
            end else if (ce) begin
                // R4: shaping lives in the low divider; n pin may use it alone
                if (cfg_q[i].low_divider_select) begin
                    pos_q[i] <= ls_lvl ^ inv;
                    neg_q[i] <= ls_lvl ^ inv;
                end else if (cfg_q[i].n_pin_low_divider) begin
                    pos_q[i] <= ms_q[i] ^ inv;
                    neg_q[i] <= ls_lvl ^ inv;
                end else begin
                    pos_q[i] <= ms_q[i] ^ inv;
                    neg_q[i] <= ms_q[i] ^ inv;
                end
            end
        end
    end

endmodule
`default_nettype wire

// file: shared/opd_pkg.sv
// opd_pkg: constants, field layouts and types for the output phase/duty block
package opd_pkg;

    // ----------------------------------------------------------------
    // sizes and timing
    // ----------------------------------------------------------------
    localparam int NUM_OUT = 3;                 // output channels
    localparam int CLK_KHZ = 125000;            // master clock rate, kHz
    // one master clock is one half period of the fast divider clock
    localparam int FAST_KHZ = CLK_KHZ / 2;
    localparam longint MAX_DUTY_KHZ = 141666;   // duty shaping ceiling, kHz

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [5:0] OFS_PHASE_CONTROL_ONE = 6'h00;
    localparam logic [5:0] OFS_PHASE_SOURCE_CONFIG = 6'h04;
    localparam logic [5:0] OFS_PHASE_STATUS_REG = 6'h08;
    localparam logic [5:0] OFS_CH_BASE = 6'h10;      // channel n at base + n*0x10
    localparam logic [1:0] CH_SUB_CTRL = 2'h0;       // channel control word
    localparam logic [1:0] CH_SUB_LOW_DIV = 2'h1;    // low_divider_value
    localparam logic [1:0] CH_SUB_DUTY = 2'h2;       // output_duty_reg
    localparam logic [1:0] CH_SUB_PHASE = 2'h3;      // output_phase_step_reg

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int PC_MODE_BIT = 0;       // 1 adjust, 0 align
    localparam int PC_PRIME_BIT = 1;      // prime_request
    localparam int PC_FIRE_BIT = 2;       // fire_request
    localparam int PC_INV_BIT = 3;        // fire_invert
    localparam int PC_CLEAR_BIT = 4;      // sequencer_clear, write only
    localparam int PS_PRIME_LSB = 0;      // prime_source_select[3:0]
    localparam int PS_FIRE_LSB = 4;       // fire_source_select[3:0]
    localparam int ST_WAIT_BIT = 0;       // waiting_for_trigger
    localparam int ST_BUSY_BIT = 1;       // busy
    localparam int ST_DONE_BIT = 2;       // step_done_latched, write 1 clears
    localparam int LOW_DIV_W = 25;

    // ----------------------------------------------------------------
    // values after reset and encodings
    // ----------------------------------------------------------------
    localparam logic RST_MODE = 1'b1;
    localparam logic [3:0] RST_PRIME_SEL = 4'h1;
    localparam logic [3:0] RST_FIRE_SEL = 4'h0;
    localparam logic MODE_ALIGN = 1'b0;
    localparam logic [3:0] SRC_PRIME_REQ = 4'h1;
    localparam logic [3:0] SRC_PRIME_APLL = 4'h2;
    localparam logic [3:0] SRC_PRIME_DPLL = 4'h3;
    localparam logic [3:0] SRC_FIRE_REQ = 4'h0;
    localparam logic [3:0] SRC_FIRE_APLL = 4'h1;
    localparam logic [3:0] SRC_FIRE_DPLL = 4'h2;
    localparam logic [3:0] SRC_FIRE_DREF = 4'h3;
    // codes 4..7 pick gpio 0..3 for either selector

    // per-channel control word, low bits of the channel control register
    typedef struct packed {
        logic format_opposite;       // [11] hstl / inverted-p 2xcmos formats
        logic n_pin_low_divider;     // [10]
        logic low_divider_select;    // [9]
        logic output_invert;         // [8]
        logic phase_step_enable;     // [7]
        logic [6:0] medium_divider_value; // [6:0]
    } opd_chan_cfg_type;

    localparam opd_chan_cfg_type RST_CHAN_CFG = 12'h000;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_ARMED = 3'b010,
        SEQ_BUSY = 3'b100
    } opd_seq_type;

endpackage

// file: verification/opd_core_monitor.sv
// opd_core_monitor: port-level checks for the output phase/duty block
`timescale 1ns/1ps
`default_nettype none
module opd_core_monitor
    import opd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [NUM_OUT-1:0] out_pos_pin,
    input wire logic [NUM_OUT-1:0] out_neg_pin
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a request seen by the slave, and the answering cycle of a read
    sequence req_s; (read || write) && waitrequest && ce; endsequence
    sequence ans_s(a); read && !waitrequest && address == a; endsequence
    bus_answer_a: assert property (req_s |=> !waitrequest) else $error("no answer");
    wait_pulse_a: assert property (!waitrequest && ce |=> waitrequest) else $error("long answer");
    answer_cause_a: assert property ($fell(waitrequest) |-> $past(read || write))
        else $error("answer without request");
    rdata_hold_a: assert property ($changed(readdata) |-> !waitrequest) else $error("data moved");
    freeze_a: assert property (!ce |=> $stable(out_pos_pin) && $stable(out_neg_pin))
        else $error("pins moved while frozen");
    status_bits_a: assert property (ans_s(OFS_PHASE_STATUS_REG) |-> readdata[31:3] == '0)
        else $error("status upper bits");
    clear_zero_a: assert property (ans_s(OFS_PHASE_CONTROL_ONE) |-> readdata[31:4] == '0)
        else $error("clear bit reads back");
    duty_width_a: assert property (ans_s(OFS_CH_BASE + 6'h08) |-> readdata[31:8] == '0)
        else $error("duty width too wide");
endmodule
bind opd_core opd_core_monitor mon_u (.clk, .rst_n, .ce, .address, .read, .write, .readdata,
    .waitrequest, .out_pos_pin, .out_neg_pin);
`default_nettype wire

// file: verification/opd_clock_sink.sv
// opd_clock_sink: clock receiver model that records the longest high time
`timescale 1ns/1ps
`default_nettype none
module opd_clock_sink (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic clk_in,
    output var int high_max
);
    int run_q; // current high time in master cycles
    // count while high; a clr mid-pulse drops the samples of that pulse counted so far
    always_ff @(posedge clk) begin
        if (!rst_n || clr) begin
            run_q <= 0;
            high_max <= 0;
        end else begin
            run_q <= clk_in ? run_q + 1 : 0;
            if (!clk_in && run_q > high_max) high_max <= run_q;
        end
    end
endmodule
`default_nettype wire

// file: verification/opd_core_tb_top.sv
// opd_core_tb_top: directed bench for the output phase/duty block
`timescale 1ns/1ps
`default_nettype none
module opd_core_tb_top
    import opd_pkg::*;
;
    logic clk = 0, rst_n = 0, ce = 1, read = 0, write = 0, clr = 0;
    logic [5:0] address = '0;
    logic [31:0] writedata = '0, readdata, q;
    logic waitrequest;
    logic [NUM_OUT-1:0] out_pos_pin, out_neg_pin;
    int err_total = 0, num_checks = 0, hl0, hl1;
    always #4 clk = ~clk;
    opd_core dut_u (.clk, .rst_n, .ce, .address, .read, .write, .writedata, .readdata,
        .waitrequest, .apll_lock(1'b0), .dpll_lock(1'b0), .dpll_ref_clk(1'b0), .gpio(4'h0),
        .out_pos_pin, .out_neg_pin);
    opd_clock_sink snk0_u (.clk, .rst_n, .clr, .clk_in(out_pos_pin[0]), .high_max(hl0));
    opd_clock_sink snk1_u (.clk, .rst_n, .clr, .clk_in(out_neg_pin[1]), .high_max(hl1));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) begin
            chk(32'h0, 32'h1);
            wrap_up;
        end
    endtask
    task automatic poll(input logic [5:0] a, input logic [31:0] e);
        int n;
        n = 0;
        do begin
            bus(0, a, 0);
            n++;
        end while (q !== e && n < 40);
        chk(q, e);
    endtask
    task automatic t_reset;
        bus(0, OFS_PHASE_CONTROL_ONE, 0);
        chk(q, 32'h1);
        bus(0, OFS_PHASE_SOURCE_CONFIG, 0);
        chk(q, 32'h1);
        bus(0, 6'h0c, 0);
        chk(q, 32'h0);
        bus(1, OFS_CH_BASE + 6'h08, 32'h1ff);
        bus(0, OFS_CH_BASE + 6'h08, 0);
        chk(q, 32'hff);
        $display("reset test done");
    endtask
    task automatic t_cancel;
        bus(1, OFS_PHASE_CONTROL_ONE, 32'h5);
        repeat (10) @(posedge clk);
        bus(0, OFS_PHASE_STATUS_REG, 0);
        chk(q, 32'h0);
        bus(1, OFS_PHASE_CONTROL_ONE, 32'h3);
        poll(OFS_PHASE_STATUS_REG, 32'h1);
        bus(1, OFS_PHASE_CONTROL_ONE, 32'h11);
        poll(OFS_PHASE_STATUS_REG, 32'h0);
        $display("cancel test done");
    endtask
    // m=4 on two outputs, +1.0 period requested on both, enabled on one
    task automatic t_adjust;
        bus(1, OFS_CH_BASE, 32'h84);
        bus(1, OFS_CH_BASE + 6'h10, 32'h04);
        bus(1, OFS_CH_BASE + 6'h0c, 32'h2);
        bus(1, OFS_CH_BASE + 6'h1c, 32'h2);
        bus(1, OFS_PHASE_CONTROL_ONE, 32'h3);
        poll(OFS_PHASE_STATUS_REG, 32'h1);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        bus(1, OFS_PHASE_CONTROL_ONE, 32'h7);
        poll(OFS_PHASE_STATUS_REG, 32'h4);
        repeat (20) @(posedge clk);
        chk(32'(hl0), 32'd6);
        chk(32'(hl1), 32'd4);
        bus(1, OFS_PHASE_STATUS_REG, 32'h4);
        bus(0, OFS_PHASE_STATUS_REG, 0);
        chk(q, 32'h0);
        bus(1, OFS_PHASE_CONTROL_ONE, 32'h0);
        bus(1, OFS_PHASE_CONTROL_ONE, 32'h2);
        clr <= 1'b1;
        bus(1, OFS_PHASE_CONTROL_ONE, 32'h4);
        clr <= 1'b0;
        poll(OFS_PHASE_STATUS_REG, 32'h4);
        repeat (20) @(posedge clk);
        chk(32'(hl0), 32'd6);
        $display("adjust test done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_cancel;
        t_adjust;
        wrap_up;
    end
endmodule
`default_nettype wire
